// *** hdl/slpcg_pkg.sv ***
/*
 * Types shared by the sleep and clock gating block.
 * Assumes slpcg_regs.svh is on the include path.
 */
package slpcg_pkg;
  `include "slpcg_regs.svh"

  typedef enum logic [1:0] {
    SLPCG_ACTIVE,
    SLPCG_SLEEPING,
    SLPCG_WAKE_HALT
  } slpcg_state_type;

  // Clock stop requests toward the peripheral domains, one bit per peripheral.
  typedef struct packed {
    logic event_routing;
    logic real_time_counter;
    logic analog_converter;
    logic analog_comparator;
    logic [6:0] port_c;
    logic [6:0] port_d;
    logic [6:0] port_e;
    logic [6:0] port_f;
  } slpcg_gates_type;

  // Domain clock enables while asleep.
  typedef struct packed {
    logic cpu_clock;
    logic periph_domain_clock;
    logic rtc_clock;
    logic system_clock_source;
    logic rtc_clock_source;
    logic input_buffers;
  } slpcg_domains_type;
endpackage

// *** hdl/slpcg_regs.svh ***
/*
 * Register offsets, field positions, reset values and timing counts of the
 * sleep and clock gating block.
 * Assumes inclusion by bare name from the package; the design modules use its macros without including it.
 */
`ifndef SLPCG_REGS_SVH
`define SLPCG_REGS_SVH

// Register indices; each register takes one word, so its byte address is four
// times its index, the clock gate bank starting at its own base.
`define SLPCG_IDX_SLEEP_CONTROL 8'h00
`define SLPCG_IDX_GENERAL_GATE 8'h00
`define SLPCG_IDX_PORT_A_GATE 8'h01
`define SLPCG_IDX_RESERVED_GATE 8'h02
`define SLPCG_IDX_PORT_C_GATE 8'h03
`define SLPCG_IDX_PORT_D_GATE 8'h04
`define SLPCG_IDX_PORT_E_GATE 8'h05
`define SLPCG_IDX_PORT_F_GATE 8'h06
`define SLPCG_GATE_BASE 8'h20

// Byte addresses on the AHB-Lite slave.
`define SLPCG_OFS_SLEEP_CONTROL (`SLPCG_IDX_SLEEP_CONTROL << 2)
`define SLPCG_OFS_GENERAL_GATE (`SLPCG_GATE_BASE + (`SLPCG_IDX_GENERAL_GATE << 2))
`define SLPCG_OFS_PORT_A_GATE (`SLPCG_GATE_BASE + (`SLPCG_IDX_PORT_A_GATE << 2))
`define SLPCG_OFS_RESERVED_GATE (`SLPCG_GATE_BASE + (`SLPCG_IDX_RESERVED_GATE << 2))
`define SLPCG_OFS_PORT_C_GATE (`SLPCG_GATE_BASE + (`SLPCG_IDX_PORT_C_GATE << 2))
`define SLPCG_OFS_PORT_D_GATE (`SLPCG_GATE_BASE + (`SLPCG_IDX_PORT_D_GATE << 2))
`define SLPCG_OFS_PORT_E_GATE (`SLPCG_GATE_BASE + (`SLPCG_IDX_PORT_E_GATE << 2))
`define SLPCG_OFS_PORT_F_GATE (`SLPCG_GATE_BASE + (`SLPCG_IDX_PORT_F_GATE << 2))
`define SLPCG_OFS_STATUS 8'h40
`define SLPCG_OFS_ANALOG_CONTROL 8'h44

// Sleep control fields.
`define SLPCG_SLEEP_ARM_BIT 0
`define SLPCG_MODE_LSB 1
`define SLPCG_MODE_MSB 3

// Sleep mode codes.
`define SLPCG_IDLE_CODE 3'h0
`define SLPCG_POWER_DOWN_CODE 3'h2
`define SLPCG_POWER_SAVE_CODE 3'h3
`define SLPCG_STAND_BY_CODE 3'h6
`define SLPCG_EXTENDED_STAND_BY_CODE 3'h7

// Writable masks of each gate register and of sleep control.
`define SLPCG_GENERAL_MASK 8'h06
`define SLPCG_PORT_A_MASK 8'h03
`define SLPCG_PORT_C_MASK 8'h5F
`define SLPCG_PORT_D_MASK 8'h19
`define SLPCG_PORT_E_MASK 8'h51
`define SLPCG_PORT_F_MASK 8'h11
`define SLPCG_SLEEP_MASK 8'h0F

// Gate bit positions.
`define SLPCG_RTC_BIT 2
`define SLPCG_EVENT_BIT 1
`define SLPCG_ADC_BIT 1
`define SLPCG_COMPARATOR_BIT 0

// Analog control register (enables of converter, comparator, reference use).
`define SLPCG_ADC_EN_BIT 0
`define SLPCG_COMPARATOR_EN_BIT 1
`define SLPCG_COMPARATOR_VREF_BIT 2
`define SLPCG_ANALOG_MASK 8'h07

`define SLPCG_RESET_VALUE 8'h00

// Halt after wake-up, in CLK_SYS cycles.
`define SLPCG_WAKE_HALT_CYCLES 3'h4

`endif

// *** hdl/slpcg_sleep_ctrl.sv ***
/*
 * Sleep sequencer: takes the sleep instruction, decides the domain enables
 * of the selected mode, accepts the wake sources of that mode and holds the
 * core for the wake-up halt.
 * Assumes the core raises the sleep strobe for one cycle per instruction.
 */
`timescale 1ns/1ps
module slpcg_sleep_ctrl
  import slpcg_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic sleep_instr,
  input wire logic armed,
  input wire logic [2:0] mode,
  input wire logic wake_any_irq,
  input wire logic wake_async_port,
  input wire logic wake_twi_match,
  input wire logic wake_rtc,
  output logic asleep,
  output logic halted,
  output logic [2:0] eff_mode,
  output slpcg_domains_type domains
);
  slpcg_state_type state_reg, state_next;
  logic [2:0] mode_reg, mode_next;
  logic [2:0] halt_reg, halt_next;
  logic wake;

  always_comb begin
    wake = wake_async_port | wake_twi_match;
    unique case (mode_reg)
      `SLPCG_IDLE_CODE: wake = wake_any_irq | wake;
      `SLPCG_POWER_SAVE_CODE, `SLPCG_EXTENDED_STAND_BY_CODE: wake = wake | wake_rtc; // [R21]
      default: wake = wake; // [R20]
    endcase
  end

  always_comb begin
    state_next = state_reg;
    mode_next = mode_reg;
    halt_next = halt_reg;
    unique case (state_reg)
      SLPCG_ACTIVE: begin
        if (sleep_instr && armed) begin // [R2]
          state_next = SLPCG_SLEEPING;
          unique case (mode)
            `SLPCG_POWER_DOWN_CODE, `SLPCG_POWER_SAVE_CODE,
            `SLPCG_STAND_BY_CODE, `SLPCG_EXTENDED_STAND_BY_CODE: mode_next = mode; // [R1]
            default: mode_next = `SLPCG_IDLE_CODE; // [R22]
          endcase
        end
      end
      SLPCG_SLEEPING: begin
        if (wake) begin
          state_next = SLPCG_WAKE_HALT;
          halt_next = `SLPCG_WAKE_HALT_CYCLES;
        end
      end
      SLPCG_WAKE_HALT: begin
        halt_next = halt_reg - 3'h1; // [R18]
        if (halt_reg == 3'h1) begin
          state_next = SLPCG_ACTIVE;
        end
      end
      default: state_next = SLPCG_ACTIVE;
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_reg <= SLPCG_ACTIVE;
      mode_reg <= `SLPCG_IDLE_CODE;
      halt_reg <= 3'h0;
    end else if (ce) begin
      state_reg <= state_next;
      mode_reg <= mode_next;
      halt_reg <= halt_next;
    end
  end

  // Domain table per mode; idle keeps everything but the CPU.
  always_comb begin
    domains = '{default: 1'b1};
    if (state_reg == SLPCG_SLEEPING) begin
      domains.cpu_clock = 1'b0;
      if (mode_reg != `SLPCG_IDLE_CODE) begin
        domains.periph_domain_clock = 1'b0;
        domains.input_buffers = 1'b0; // [R13]
        domains.rtc_clock = (mode_reg == `SLPCG_POWER_SAVE_CODE) ||
                            (mode_reg == `SLPCG_EXTENDED_STAND_BY_CODE);
        domains.rtc_clock_source = domains.rtc_clock;
        domains.system_clock_source = mode_reg[2];
      end
    end else if (state_reg == SLPCG_WAKE_HALT) begin
      domains.cpu_clock = 1'b0;
    end
  end

  assign asleep = (state_reg == SLPCG_SLEEPING);
  assign halted = (state_reg != SLPCG_ACTIVE);
  assign eff_mode = mode_reg;
endmodule // slpcg_sleep_ctrl

// *** hdl/slpcg_top.sv ***
/*
 * Sleep and clock gating block: AHB-Lite register file holding the sleep
 * control and the per-peripheral clock stop registers, the sleep sequencer,
 * and the keep-alive decisions for analog, watchdog and brownout logic.
 * Assumes a single AHB-Lite master on CLK_SYS and a core that pulses
 * SLEEP_INSTR when it executes the sleep instruction.
 */
// Notes on behaviour
// [R1]: Mode codes 000 idle, 010 down, 011 save, 110 standby, 111 extended; others reserved.
// [R2]: Sleep instruction only sleeps when the arm bit zero is set.
// [R3]: Software arms just before sleeping and disarms right after waking.
// [R4]: Software writes zero to the upper four bits of sleep control.
// [R5]: General bit two stops the real-time counter clock; software reinitialises it.
// [R6]: General bit one stops event routing clock; it resumes from frozen state.
// [R7]: Port A bit one stops converter clock, bit zero comparator, cores included.
// [R8]: Software disables converter and comparator before stopping their clocks.
// [R9]: Port bits six to zero stop two-wire, serial one, zero, SPI, fine-edge, timers.
// [R10]: A timer resumes from exactly its frozen state when its bit clears.
// [R11]: Software reinitialises two-wire, serial, SPI and fine-edge after ungating.
// [R12]: Gate bank: general, port A, reserved, ports C to F; absent bits stay zero.
// [R13]: Modes stopping the peripheral clock disable pin input buffers.
// [R14]: An enabled converter stays on in sleep; re-enable forces an extended conversion.
// [R15]: Comparator auto-off outside idle; its reference stays on until software disables it.
// [R16]: An enabled watchdog keeps running in all sleep modes.
// [R17]: A fuse-enabled brownout detector stays on; deeper modes may pick off or sampled.
// [R18]: After any wake-up the core stays halted four cycles.
// [R19]: A gated peripheral is frozen and its registers are inaccessible.
// [R20]: Power-down stops all clocks; only two-wire match or async port wakes.
// [R21]: Power-save keeps the real-time counter running and lets it wake.
// [R22]: A reserved mode code, armed and executed, behaves as idle.
`timescale 1ns/1ps
module slpcg_top
  import slpcg_pkg::*;
(
  input wire logic CLK_SYS,
  input wire logic RESET,
  input wire logic CE,
  input wire logic HSEL,
  input wire logic [31:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic [2:0] HSIZE,
  input wire logic [31:0] HWDATA,
  input wire logic HREADY,
  output logic [31:0] HRDATA,
  output logic HREADYOUT,
  output logic HRESP,
  input wire logic SLEEP_INSTR,
  input wire logic WAKE_ANY_IRQ,
  input wire logic WAKE_ASYNC_PORT,
  input wire logic WAKE_TWI_MATCH,
  input wire logic WAKE_RTC,
  input wire logic WATCHDOG_ENABLED,
  input wire logic [1:0] BROWNOUT_ACTIVE_SETTING,
  input wire logic [1:0] BROWNOUT_SLEEP_SETTING,
  output logic CPU_HALT,
  output logic SLEEPING,
  output logic [2:0] SLEEP_MODE,
  output slpcg_domains_type DOMAIN_ENABLES,
  output slpcg_gates_type CLOCK_STOPS,
  output logic ADC_ENABLE,
  output logic ADC_EXTENDED_CONVERSION,
  output logic COMPARATOR_ENABLE,
  output logic COMPARATOR_VREF_ENABLE,
  output logic WATCHDOG_RUN,
  output logic [1:0] BROWNOUT_SETTING
);
  logic [7:0] sleep_control_reg, sleep_control_next;
  logic [7:0] general_clock_gate_reg, general_clock_gate_next;
  logic [7:0] port_a_analog_clock_gate_reg, port_a_analog_clock_gate_next;
  logic [7:0] port_c_clock_gate_reg, port_c_clock_gate_next;
  logic [7:0] port_d_clock_gate_reg, port_d_clock_gate_next;
  logic [7:0] port_e_clock_gate_reg, port_e_clock_gate_next;
  logic [7:0] port_f_clock_gate_reg, port_f_clock_gate_next;
  logic [7:0] analog_control_reg, analog_control_next;
  logic extended_pending_reg, extended_pending_next;
  logic wr_pending_reg, wr_pending_next;
  logic [7:0] wr_addr_reg, wr_addr_next;
  logic [31:0] hrdata_reg, hrdata_next;
  logic asleep, halted;
  logic [2:0] eff_mode;
  slpcg_domains_type domains;
  logic take;
  logic [7:0] wdata;
  logic [7:0] rd_value;

  slpcg_sleep_ctrl u_sleep_ctrl (
    .clk(CLK_SYS),
    .rst(RESET),
    .ce(CE),
    .sleep_instr(SLEEP_INSTR),
    .armed(sleep_control_reg[`SLPCG_SLEEP_ARM_BIT]),
    .mode(sleep_control_reg[`SLPCG_MODE_MSB:`SLPCG_MODE_LSB]),
    .wake_any_irq(WAKE_ANY_IRQ),
    .wake_async_port(WAKE_ASYNC_PORT),
    .wake_twi_match(WAKE_TWI_MATCH),
    .wake_rtc(WAKE_RTC),
    .asleep(asleep),
    .halted(halted),
    .eff_mode(eff_mode),
    .domains(domains)
  );

  // The slave is always ready: writes land at the clock edge that ends the data phase.
  assign take = HSEL && HREADY && HTRANS[1];
  assign wdata = HWDATA[7:0];
  assign HREADYOUT = 1'b1;
  assign HRESP = 1'b0;

  always_comb begin
    unique case (HADDR[7:0])
      `SLPCG_OFS_SLEEP_CONTROL: rd_value = sleep_control_reg;
      `SLPCG_OFS_GENERAL_GATE: rd_value = general_clock_gate_reg;
      `SLPCG_OFS_PORT_A_GATE: rd_value = port_a_analog_clock_gate_reg;
      `SLPCG_OFS_PORT_C_GATE: rd_value = port_c_clock_gate_reg;
      `SLPCG_OFS_PORT_D_GATE: rd_value = port_d_clock_gate_reg;
      `SLPCG_OFS_PORT_E_GATE: rd_value = port_e_clock_gate_reg;
      `SLPCG_OFS_PORT_F_GATE: rd_value = port_f_clock_gate_reg;
      `SLPCG_OFS_STATUS: rd_value = {3'h0, extended_pending_reg, halted, eff_mode};
      `SLPCG_OFS_ANALOG_CONTROL: rd_value = analog_control_reg;
      default: rd_value = 8'h00; // [R12]
    endcase
  end

  always_comb begin
    wr_pending_next = take && HWRITE;
    wr_addr_next = take ? HADDR[7:0] : wr_addr_reg;
    hrdata_next = (take && !HWRITE) ? {24'h000000, rd_value} : hrdata_reg;
    sleep_control_next = sleep_control_reg;
    general_clock_gate_next = general_clock_gate_reg;
    port_a_analog_clock_gate_next = port_a_analog_clock_gate_reg;
    port_c_clock_gate_next = port_c_clock_gate_reg;
    port_d_clock_gate_next = port_d_clock_gate_reg;
    port_e_clock_gate_next = port_e_clock_gate_reg;
    port_f_clock_gate_next = port_f_clock_gate_reg;
    analog_control_next = analog_control_reg;
    if (wr_pending_reg) begin
      unique case (wr_addr_reg)
        // Upper bits are masked so a careless write cannot leave junk behind.
        `SLPCG_OFS_SLEEP_CONTROL: sleep_control_next = wdata & `SLPCG_SLEEP_MASK; // [R4]
        `SLPCG_OFS_GENERAL_GATE: general_clock_gate_next = wdata & `SLPCG_GENERAL_MASK; // [R5] [R6]
        `SLPCG_OFS_PORT_A_GATE: port_a_analog_clock_gate_next = wdata & `SLPCG_PORT_A_MASK; // [R7]
        `SLPCG_OFS_PORT_C_GATE: port_c_clock_gate_next = wdata & `SLPCG_PORT_C_MASK; // [R9]
        `SLPCG_OFS_PORT_D_GATE: port_d_clock_gate_next = wdata & `SLPCG_PORT_D_MASK; // [R12]
        `SLPCG_OFS_PORT_E_GATE: port_e_clock_gate_next = wdata & `SLPCG_PORT_E_MASK; // [R12]
        `SLPCG_OFS_PORT_F_GATE: port_f_clock_gate_next = wdata & `SLPCG_PORT_F_MASK; // [R12]
        `SLPCG_OFS_ANALOG_CONTROL: analog_control_next = wdata & `SLPCG_ANALOG_MASK;
        default: sleep_control_next = sleep_control_reg;
      endcase
    end
    // An off-to-on edge of the converter arms an extended conversion.
    extended_pending_next = extended_pending_reg;
    if (!analog_control_reg[`SLPCG_ADC_EN_BIT] && analog_control_next[`SLPCG_ADC_EN_BIT]) begin
      extended_pending_next = 1'b1; // [R14]
    end
  end

  always_ff @(posedge CLK_SYS or posedge RESET) begin
    if (RESET) begin
      sleep_control_reg <= `SLPCG_RESET_VALUE;
      general_clock_gate_reg <= `SLPCG_RESET_VALUE;
      port_a_analog_clock_gate_reg <= `SLPCG_RESET_VALUE;
      port_c_clock_gate_reg <= `SLPCG_RESET_VALUE;
      port_d_clock_gate_reg <= `SLPCG_RESET_VALUE;
      port_e_clock_gate_reg <= `SLPCG_RESET_VALUE;
      port_f_clock_gate_reg <= `SLPCG_RESET_VALUE;
      analog_control_reg <= `SLPCG_RESET_VALUE;
      extended_pending_reg <= 1'b0;
      wr_pending_reg <= 1'b0;
      wr_addr_reg <= 8'h00;
      hrdata_reg <= 32'h00000000;
    end else if (CE) begin
      sleep_control_reg <= sleep_control_next;
      general_clock_gate_reg <= general_clock_gate_next;
      port_a_analog_clock_gate_reg <= port_a_analog_clock_gate_next;
      port_c_clock_gate_reg <= port_c_clock_gate_next;
      port_d_clock_gate_reg <= port_d_clock_gate_next;
      port_e_clock_gate_reg <= port_e_clock_gate_next;
      port_f_clock_gate_reg <= port_f_clock_gate_next;
      analog_control_reg <= analog_control_next;
      extended_pending_reg <= extended_pending_next;
      wr_pending_reg <= wr_pending_next;
      wr_addr_reg <= wr_addr_next;
      hrdata_reg <= hrdata_next;
    end
  end

  assign HRDATA = hrdata_reg;

  // Stops are level requests; the peripheral domains freeze in place and
  // block their own register access while stopped. [R19]
  always_comb begin
    CLOCK_STOPS.event_routing = general_clock_gate_reg[`SLPCG_EVENT_BIT]; // [R6]
    CLOCK_STOPS.real_time_counter = general_clock_gate_reg[`SLPCG_RTC_BIT]; // [R5]
    CLOCK_STOPS.analog_converter = port_a_analog_clock_gate_reg[`SLPCG_ADC_BIT]; // [R7]
    CLOCK_STOPS.analog_comparator = port_a_analog_clock_gate_reg[`SLPCG_COMPARATOR_BIT]; // [R7]
    CLOCK_STOPS.port_c = port_c_clock_gate_reg[6:0]; // [R9] [R10]
    CLOCK_STOPS.port_d = port_d_clock_gate_reg[6:0];
    CLOCK_STOPS.port_e = port_e_clock_gate_reg[6:0];
    CLOCK_STOPS.port_f = port_f_clock_gate_reg[6:0];
  end

  assign DOMAIN_ENABLES = domains; // [R13] [R20] [R21]
  assign CPU_HALT = halted; // [R18]
  assign SLEEPING = asleep;
  assign SLEEP_MODE = eff_mode;
  assign ADC_ENABLE = analog_control_reg[`SLPCG_ADC_EN_BIT]; // [R14]
  assign ADC_EXTENDED_CONVERSION = extended_pending_reg;
  // Comparator drops out of every sleep except idle, but its reference use
  // keeps the reference alive until software clears the comparator enable.
  assign COMPARATOR_ENABLE = analog_control_reg[`SLPCG_COMPARATOR_EN_BIT] &&
                             !(asleep && eff_mode != `SLPCG_IDLE_CODE); // [R15]
  assign COMPARATOR_VREF_ENABLE = analog_control_reg[`SLPCG_COMPARATOR_EN_BIT] &&
                                  analog_control_reg[`SLPCG_COMPARATOR_VREF_BIT]; // [R15]
  assign WATCHDOG_RUN = WATCHDOG_ENABLED; // [R16]
  assign BROWNOUT_SETTING = (asleep && eff_mode != `SLPCG_IDLE_CODE) ?
                            BROWNOUT_SLEEP_SETTING : BROWNOUT_ACTIVE_SETTING; // [R17]
endmodule // slpcg_top

// *** testbench/slpcg_core_model.sv ***
/*
 * Far side model: a core that issues the sleep instruction and one timer
 * in a gated peripheral domain.
 * Assumes the block's clock and reset.
 */
`timescale 1ns/1ps
module slpcg_core_model (
  input wire logic clk,
  input wire logic rst,
  input wire logic go_sleep,
  input wire logic halted,
  input wire logic timer_stop,
  output logic sleep_pulse,
  output logic [15:0] timer_count
);
  // A halted core executes nothing, and a held request gives separate pulses.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sleep_pulse <= 1'h0;
      timer_count <= 16'h0000;
    end else begin
      sleep_pulse <= go_sleep && !halted && !sleep_pulse;
      if (!timer_stop) begin
        timer_count <= timer_count + 16'h0001;
      end
    end
  end
endmodule // slpcg_core_model

// *** testbench/slpcg_monitor.sv ***
/*
 * Port checker of the sleep and clock gating block.
 * Assumes it is bound to slpcg_top and sees only that module's ports.
 */
`timescale 1ns/1ps
module slpcg_monitor
  import slpcg_pkg::*;
(
  input wire logic CLK_SYS,
  input wire logic RESET,
  input wire logic SLEEP_INSTR,
  input wire logic WAKE_ASYNC_PORT,
  input wire logic WAKE_TWI_MATCH,
  input wire logic WAKE_RTC,
  input wire logic WATCHDOG_ENABLED,
  input wire logic [1:0] BROWNOUT_ACTIVE_SETTING,
  input wire logic [1:0] BROWNOUT_SLEEP_SETTING,
  input wire logic CPU_HALT,
  input wire logic SLEEPING,
  input wire logic [2:0] SLEEP_MODE,
  input wire slpcg_domains_type DOMAIN_ENABLES,
  input wire logic ADC_ENABLE,
  input wire logic ADC_EXTENDED_CONVERSION,
  input wire logic COMPARATOR_ENABLE,
  input wire logic WATCHDOG_RUN,
  input wire logic [1:0] BROWNOUT_SETTING
);
  default clocking cb @(posedge CLK_SYS);
  endclocking
  default disable iff (RESET);
  logic deep;
  logic rtc_mode;
  assign deep = SLEEPING && (SLEEP_MODE != 3'h0);
  assign rtc_mode = (SLEEP_MODE == 3'h3) || (SLEEP_MODE == 3'h7);
  property p_cause; $rose(SLEEPING) |-> $past(SLEEP_INSTR); endproperty
  a_cause: assert property (p_cause) else $error("sleep entered without instruction");
  property p_halt; $fell(SLEEPING) |-> CPU_HALT [*4] ##1 !CPU_HALT; endproperty
  a_halt: assert property (p_halt) else $error("wake halt length wrong");
  property p_mode; SLEEPING |-> SLEEP_MODE inside {3'h0, 3'h2, 3'h3, 3'h6, 3'h7}; endproperty
  a_mode: assert property (p_mode) else $error("reserved mode kept");
  property p_pins; deep |-> !DOMAIN_ENABLES.input_buffers && !DOMAIN_ENABLES.periph_domain_clock; endproperty
  a_pins: assert property (p_pins) else $error("input buffers on in deep sleep");
  property p_hold; deep && !WAKE_ASYNC_PORT && !WAKE_TWI_MATCH && !(rtc_mode && WAKE_RTC) |=> SLEEPING; endproperty
  a_hold: assert property (p_hold) else $error("woken by a source of another mode");
  property p_rtc; SLEEPING && rtc_mode |-> DOMAIN_ENABLES.rtc_clock && DOMAIN_ENABLES.rtc_clock_source; endproperty
  a_rtc: assert property (p_rtc) else $error("counter clock stopped");
  property p_ac; deep |-> !COMPARATOR_ENABLE; endproperty
  a_ac: assert property (p_ac) else $error("comparator on in deep sleep");
  property p_wdog; WATCHDOG_RUN == WATCHDOG_ENABLED; endproperty
  a_wdog: assert property (p_wdog) else $error("watchdog run differs");
  property p_bod; BROWNOUT_SETTING == (deep ? BROWNOUT_SLEEP_SETTING : BROWNOUT_ACTIVE_SETTING); endproperty
  a_bod: assert property (p_bod) else $error("brownout setting wrong");
  property p_ext; $rose(ADC_ENABLE) |-> ##[0:1] ADC_EXTENDED_CONVERSION; endproperty
  a_ext: assert property (p_ext) else $error("extended conversion not flagged");
  c_deep_wake: cover property (deep ##1 !SLEEPING);
  c_idle: cover property (SLEEPING && SLEEP_MODE == 3'h0);
  c_halt_end: cover property ($fell(CPU_HALT));
endmodule // slpcg_monitor

bind slpcg_top slpcg_monitor u_monitor (.CLK_SYS, .RESET, .SLEEP_INSTR, .WAKE_ASYNC_PORT, .WAKE_TWI_MATCH, .WAKE_RTC,
  .WATCHDOG_ENABLED, .BROWNOUT_ACTIVE_SETTING, .BROWNOUT_SLEEP_SETTING, .CPU_HALT, .SLEEPING, .SLEEP_MODE,
  .DOMAIN_ENABLES, .ADC_ENABLE, .ADC_EXTENDED_CONVERSION, .COMPARATOR_ENABLE, .WATCHDOG_RUN, .BROWNOUT_SETTING);

// *** testbench/testbench.sv ***
/*
 * Self-checking bench of the sleep and clock gating block.
 * Assumes slpcg_top, slpcg_core_model and the bound checker are compiled.
 */
`timescale 1ns/1ps
module testbench;
  logic CLK_SYS, RESET, CE, HSEL, HWRITE, HRESP, HREADYOUT, SLEEP_INSTR, go_sleep, CPU_HALT, SLEEPING;
  logic WAKE_ANY_IRQ, WAKE_ASYNC_PORT, WAKE_TWI_MATCH, WAKE_RTC, WATCHDOG_ENABLED, WATCHDOG_RUN;
  logic ADC_ENABLE, ADC_EXTENDED_CONVERSION, COMPARATOR_ENABLE, COMPARATOR_VREF_ENABLE;
  logic [31:0] HADDR, HWDATA, HRDATA, CLOCK_STOPS;
  logic [1:0] HTRANS, BROWNOUT_ACTIVE_SETTING, BROWNOUT_SLEEP_SETTING, BROWNOUT_SETTING;
  logic [2:0] HSIZE, SLEEP_MODE;
  logic [5:0] DOMAIN_ENABLES;
  logic [15:0] timer_count;
  int error_cnt = 0;
  int comparisons = 0;
  slpcg_top DUT (.CLK_SYS, .RESET, .CE, .HSEL, .HADDR, .HTRANS, .HWRITE, .HSIZE, .HWDATA, .HREADY(HREADYOUT),
    .HRDATA, .HREADYOUT, .HRESP, .SLEEP_INSTR, .WAKE_ANY_IRQ, .WAKE_ASYNC_PORT, .WAKE_TWI_MATCH, .WAKE_RTC,
    .WATCHDOG_ENABLED, .BROWNOUT_ACTIVE_SETTING, .BROWNOUT_SLEEP_SETTING, .CPU_HALT, .SLEEPING, .SLEEP_MODE,
    .DOMAIN_ENABLES, .CLOCK_STOPS, .ADC_ENABLE, .ADC_EXTENDED_CONVERSION, .COMPARATOR_ENABLE, .COMPARATOR_VREF_ENABLE,
    .WATCHDOG_RUN, .BROWNOUT_SETTING);
  // Bit 21 of the stop vector is timer zero of port C.
  slpcg_core_model partner (.clk(CLK_SYS), .rst(RESET), .go_sleep, .halted(CPU_HALT),
    .timer_stop(CLOCK_STOPS[21]), .sleep_pulse(SLEEP_INSTR), .timer_count);

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic tally_and_finish();
    $display("Comparisons %0d, mismatches %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic bus(input logic wr, input logic [7:0] adr, input logic [7:0] wd, output logic [31:0] rd);
    int n;
    @(posedge CLK_SYS);
    HSEL <= 1'h1;
    HTRANS <= 2'h2;
    HADDR <= {24'h0, adr};
    HWRITE <= wr;
    n = 0;
    @(posedge CLK_SYS);
    while (HREADYOUT !== 1'h1 && n < 50) begin
      @(posedge CLK_SYS);
      n++;
    end
    HSEL <= 1'h0;
    HTRANS <= 2'h0;
    HWDATA <= {24'h0, wd};
    @(posedge CLK_SYS);
    while (HREADYOUT !== 1'h1 && n < 100) begin
      @(posedge CLK_SYS);
      n++;
    end
    rd = HRDATA;
    chk("response", 32'h0, HRESP);
    chk("ready", 32'h1, HREADYOUT);
  endtask

  task automatic t_regs();
    logic [7:0] adr [9] = '{8'h00, 8'h20, 8'h24, 8'h28, 8'h2C, 8'h30, 8'h34, 8'h38, 8'h7C};
    logic [7:0] msk [9] = '{8'h0E, 8'h06, 8'h03, 8'h00, 8'h5F, 8'h19, 8'h51, 8'h11, 8'h00};
    logic [31:0] rd;
    for (int i = 0; i < 9; i++) begin
      bus(1'h0, adr[i], 8'h00, rd);
      chk("reset value", 32'h0, rd);
      bus(1'h1, adr[i], (i == 0) ? 8'h0E : 8'hFF, rd);
      bus(1'h0, adr[i], 8'h00, rd);
      chk("masked readback", {24'h0, msk[i]}, rd);
    end
    chk("clock stops", {4'hF, 7'h5F, 7'h19, 7'h51, 7'h11}, CLOCK_STOPS);
    for (int i = 0; i < 9; i++) begin
      bus(1'h1, adr[i], 8'h00, rd);
    end
    @(negedge CLK_SYS);
    chk("clock stops clear", 32'h0, CLOCK_STOPS);
  endtask

  task automatic t_analog();
    logic [31:0] rd;
    chk("extended before", 32'h0, ADC_EXTENDED_CONVERSION);
    bus(1'h1, 8'h44, 8'h07, rd);
    repeat (2) @(negedge CLK_SYS);
    chk("analog on", 32'h7, {ADC_ENABLE, COMPARATOR_ENABLE, COMPARATOR_VREF_ENABLE});
    chk("extended after", 32'h1, ADC_EXTENDED_CONVERSION);
    bus(1'h0, 8'h40, 8'h00, rd);
    chk("status", 32'h10, rd);
  endtask

  task automatic t_unarmed();
    logic [31:0] rd;
    bus(1'h1, 8'h00, 8'h04, rd);
    go_sleep <= 1'h1;
    repeat (4) @(posedge CLK_SYS);
    go_sleep <= 1'h0;
    WATCHDOG_ENABLED <= 1'h0;
    @(negedge CLK_SYS);
    chk("unarmed", 32'h0, {SLEEPING, CPU_HALT});
    chk("watchdog off", 32'h0, WATCHDOG_RUN);
    @(posedge CLK_SYS);
    WATCHDOG_ENABLED <= 1'h1;
  endtask

  task automatic t_sleep(input logic [2:0] m);
    logic [2:0] em;
    logic [5:0] dom;
    logic [31:0] rd;
    int k;
    em = (m inside {3'h1, 3'h4, 3'h5}) ? 3'h0 : m;
    case (em)
      3'h0: dom = 6'h1F;
      3'h2: dom = 6'h00;
      3'h3: dom = 6'h0A;
      3'h6: dom = 6'h04;
      default: dom = 6'h0E;
    endcase
    bus(1'h1, 8'h00, {4'h0, m, 1'h1}, rd);
    go_sleep <= 1'h1;
    @(posedge CLK_SYS);
    go_sleep <= 1'h0;
    repeat (3) @(negedge CLK_SYS);
    chk("asleep", 32'h3, {SLEEPING, CPU_HALT});
    chk("sleep mode", em, SLEEP_MODE);
    chk("domains", dom, DOMAIN_ENABLES);
    chk("analog", {em == 3'h0, 2'h3}, {COMPARATOR_ENABLE, ADC_ENABLE, COMPARATOR_VREF_ENABLE});
    chk("keep alive", {((em == 3'h0) ? 2'h2 : 2'h1), 1'h1}, {BROWNOUT_SETTING, WATCHDOG_RUN});
    @(posedge CLK_SYS);
    WAKE_ANY_IRQ <= 1'h1;
    WAKE_RTC <= (em == 3'h2 || em == 3'h6);
    if (em != 3'h0) begin
      repeat (3) @(negedge CLK_SYS);
      chk("no early wake", 32'h1, SLEEPING);
      @(posedge CLK_SYS);
      WAKE_RTC <= (em == 3'h3 || em == 3'h7);
      WAKE_TWI_MATCH <= (em == 3'h6);
      WAKE_ASYNC_PORT <= (em == 3'h2);
    end
    k = 0;
    while (SLEEPING !== 1'h0 && k < 20) begin
      @(negedge CLK_SYS);
      k++;
    end
    k = 0;
    while (CPU_HALT === 1'h1 && k < 20) begin
      @(negedge CLK_SYS);
      k++;
    end
    chk("wake halt", 32'd4, k);
    chk("domains awake", 32'h3F, DOMAIN_ENABLES);
    @(posedge CLK_SYS);
    {WAKE_ANY_IRQ, WAKE_ASYNC_PORT, WAKE_TWI_MATCH, WAKE_RTC} <= 4'h0;
    bus(1'h1, 8'h00, 8'h00, rd);
  endtask

  task automatic t_timer();
    logic [31:0] rd;
    logic [15:0] held;
    bus(1'h1, 8'h2C, 8'h01, rd);
    @(negedge CLK_SYS);
    held = timer_count;
    repeat (8) @(negedge CLK_SYS);
    chk("frozen timer", held, timer_count);
    bus(1'h1, 8'h2C, 8'h00, rd);
    repeat (3) @(negedge CLK_SYS);
    chk("timer resumed", held + 16'h2, timer_count);
    @(posedge CLK_SYS);
    CE <= 1'h0;
    bus(1'h1, 8'h2C, 8'h01, rd);
    CE <= 1'h1;
    @(negedge CLK_SYS);
    chk("enable low freezes", 32'h0, CLOCK_STOPS);
  endtask

  initial begin
    CLK_SYS = 1'h0;
    forever #12.5 CLK_SYS = ~CLK_SYS;
  end

  initial begin
    #200us;
    error_cnt++;
    $display("MISMATCH watchdog expected done seen timeout");
    tally_and_finish();
  end

  // Outputs other than the bus task's reads and the first clock stops check are sampled at the falling edge so that no check races the update it looks for.
  initial begin
    RESET = 1'h1;
    CE = 1'h1;
    HSEL = 1'h0;
    HWRITE = 1'h0;
    HTRANS = 2'h0;
    HSIZE = 3'h2;
    HADDR = 32'h0;
    HWDATA = 32'h0;
    go_sleep = 1'h0;
    {WAKE_ANY_IRQ, WAKE_ASYNC_PORT, WAKE_TWI_MATCH, WAKE_RTC} = 4'h0;
    WATCHDOG_ENABLED = 1'h1;
    BROWNOUT_ACTIVE_SETTING = 2'h2;
    BROWNOUT_SLEEP_SETTING = 2'h1;
    repeat (20) @(posedge CLK_SYS);
    RESET <= 1'h0;
    t_regs();
    t_analog();
    t_unarmed();
    for (int m = 0; m < 8; m++) begin
      t_sleep(m[2:0]);
    end
    t_timer();
    tally_and_finish();
  end
endmodule // testbench
